// ### pkg/sirq_cfg.svh
// Purpose: Offsets, field positions and reset values of the slot irq block
// Assumes: Register indices scale by four to APB byte addresses
// Notes: Definitions only
`ifndef SIRQ_CFG_SVH
`define SIRQ_CFG_SVH

`define SIRQ_ADDR_W 12
`define SIRQ_IDX_FORCE 12'h052
`define SIRQ_IDX_SUMMARY 12'h0FC
`define SIRQ_IDX_VERSION 12'h0FE
`define SIRQ_IDX_CTRL 12'h02F
`define SIRQ_IDX_ERR_STS 12'h030
`define SIRQ_IDX_STS_EN 12'h034
`define SIRQ_IDX_SIG_EN 12'h038
`define SIRQ_BYTE_ADDR(idx) (12'((idx) << 2))

`define SIRQ_NUM_SLOTS 8
`define SIRQ_ERR_VALID 16'hF3FF
`define SIRQ_ERR_RESET 16'h0000
`define SIRQ_EN_RESET 16'h0000
`define SIRQ_CTRL_FULL_RST 0
`define SIRQ_SPEC_V100 8'h00
`define SIRQ_SPEC_V200 8'h01
`define SIRQ_VENDOR_VER 8'h5A

`endif

// ### pkg/sirq_pkg.sv
// Purpose: Types shared by the slot irq block
// Assumes: Constants live in sirq_cfg.svh
// Notes: Register select codes are binary
package sirq_pkg;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sirq_apb_req_t;

  typedef enum logic [2:0] {
    SIRQ_REG_NONE = 3'b000,
    SIRQ_REG_FORCE = 3'b001,
    SIRQ_REG_SUMMARY = 3'b010,
    SIRQ_REG_VERSION = 3'b011,
    SIRQ_REG_CTRL = 3'b100,
    SIRQ_REG_ERR_STS = 3'b101,
    SIRQ_REG_STS_EN = 3'b110,
    SIRQ_REG_SIG_EN = 3'b111
  } sirq_reg_t;

endpackage

// ### rtl/sirq_top.sv
// Purpose: Slot summary, revision and error force-event registers on APB
// Assumes: Slot request pins are asynchronous; one clock, pclk
// Notes: Error status, enables and control kept here to close the irq path
`timescale 1ns/1ps
`include "sirq_cfg.svh"

// Overview of operation
// - Summary bit is slot interrupt OR wake
// - Up to eight slots; upper byte reserved
// - Bit n reports slot n+1
// - Reset or full reset drops interrupt output
// - Upper version byte is fixed maker value
// - Lower version byte gives specification revision
// - Force location stores nothing itself
// - Force ones set status; zeros change nothing
// - Forced bit shows only when status enabled
// - Interrupt needs status and signal enable
// - Force word follows the error bit layout
module sirq_top
  import sirq_pkg::*;
#(
  parameter int NUM_SLOTS = `SIRQ_NUM_SLOTS,
  parameter int OWN_SLOT = 0,
  parameter logic [7:0] VENDOR_VER = `SIRQ_VENDOR_VER, // Arbitrary value
  parameter logic [7:0] SPEC_VER = `SIRQ_SPEC_V200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SLOTS-1:0] slot_irq,
  input wire logic [NUM_SLOTS-1:0] slot_wake,
  input wire logic [15:0] err_event,
  output logic irq,
  output logic full_controller_reset
);

  // Elaboration guards; the summary byte has room for eight slots only
  if (NUM_SLOTS < 1 || NUM_SLOTS > `SIRQ_NUM_SLOTS) begin : g_bad_slots
    $error("NUM_SLOTS must be 1 to 8");
  end
  // Own slot must land inside the summary field
  if (OWN_SLOT < 0 || OWN_SLOT >= NUM_SLOTS) begin : g_bad_own
    $error("OWN_SLOT outside slot range");
  end
  // Only the two defined revision codes may be reported
  if (SPEC_VER != `SIRQ_SPEC_V100 &&
      SPEC_VER != `SIRQ_SPEC_V200) begin : g_bad_spec
    $error("SPEC_VER is a reserved encoding");
  end

  // All checks below share this clock and reset
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sirq_apb_req_t req;
  assign req = '{sel: psel, en: penable, wr: pwrite,
                 addr: paddr, wdata: pwdata};

  // Decode
  sirq_reg_t reg_sel;
  assign reg_sel =
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_FORCE)) ? SIRQ_REG_FORCE :
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_SUMMARY)) ? SIRQ_REG_SUMMARY :
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_VERSION)) ? SIRQ_REG_VERSION :
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_CTRL)) ? SIRQ_REG_CTRL :
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_ERR_STS)) ? SIRQ_REG_ERR_STS :
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_STS_EN)) ? SIRQ_REG_STS_EN :
    (req.addr == `SIRQ_BYTE_ADDR(`SIRQ_IDX_SIG_EN)) ? SIRQ_REG_SIG_EN :
    SIRQ_REG_NONE;

  wire access = req.sel && req.en && pce;
  wire unmapped = (reg_sel == SIRQ_REG_NONE);
  // Read-only targets refuse writes with an error
  wire ro_hit = (reg_sel == SIRQ_REG_SUMMARY) ||
                (reg_sel == SIRQ_REG_VERSION);
  wire wr_ok = access && req.wr && !unmapped && !ro_hit;
  wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wval = req.wdata[15:0] & wmask;

  wire wr_force = wr_ok && (reg_sel == SIRQ_REG_FORCE);
  wire wr_ctrl = wr_ok && (reg_sel == SIRQ_REG_CTRL);
  wire wr_sts = wr_ok && (reg_sel == SIRQ_REG_ERR_STS);
  wire wr_sts_en = wr_ok && (reg_sel == SIRQ_REG_STS_EN);
  wire wr_sig_en = wr_ok && (reg_sel == SIRQ_REG_SIG_EN);

  // Pin synchronisers; stage one feeds only stage two
  logic [NUM_SLOTS-1:0] irq_s1_r, irq_s2_r;
  logic [NUM_SLOTS-1:0] wake_s1_r, wake_s2_r;
  logic [15:0] evt_s1_r, evt_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      wake_s1_r <= '0;
      wake_s2_r <= '0;
      evt_s1_r <= '0;
      evt_s2_r <= '0;
    end else if (pce) begin
      irq_s1_r <= slot_irq;
      irq_s2_r <= irq_s1_r;
      wake_s1_r <= slot_wake;
      wake_s2_r <= wake_s1_r;
      evt_s1_r <= err_event;
      evt_s2_r <= evt_s1_r;
    end
  end

  // Control: full reset is self-clearing, one cycle wide
  logic full_rst_r;
  wire full_rst_nxt = wr_ctrl && wval[`SIRQ_CTRL_FULL_RST];

  // Error status, enables
  logic [15:0] err_sts_r, sts_en_r, sig_en_r;
  logic [15:0] err_sts_nxt, sts_en_nxt, sig_en_nxt;
  logic irq_r;

  // Force path adds to the status set term; it is never stored
  wire [15:0] force_set = wr_force ? wval : 16'h0000;
  // Hardware events and forced ones only land when status enabled
  wire [15:0] set_bits = (evt_s2_r | force_set) & sts_en_r
                         & `SIRQ_ERR_VALID;
  wire [15:0] clr_bits = wr_sts ? wval : 16'h0000;

  // Set beats a same-cycle write-one-to-clear
  assign err_sts_nxt = full_rst_r ? `SIRQ_ERR_RESET :
                       ((err_sts_r & ~clr_bits) | set_bits);
  assign sts_en_nxt = full_rst_r ? `SIRQ_EN_RESET :
                      wr_sts_en ? (wval & `SIRQ_ERR_VALID) : sts_en_r;
  assign sig_en_nxt = full_rst_r ? `SIRQ_EN_RESET :
                      wr_sig_en ? (wval & `SIRQ_ERR_VALID) : sig_en_r;
  wire irq_nxt = |(err_sts_nxt & sig_en_nxt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_sts_r <= `SIRQ_ERR_RESET;
      sts_en_r <= `SIRQ_EN_RESET;
      sig_en_r <= `SIRQ_EN_RESET;
      full_rst_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (pce) begin
      err_sts_r <= err_sts_nxt;
      sts_en_r <= sts_en_nxt;
      sig_en_r <= sig_en_nxt;
      full_rst_r <= full_rst_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Slot summary; own slot reports this controller's interrupt
  logic [NUM_SLOTS-1:0] own_vec;
  logic [7:0] summary_r;
  logic [7:0] summary_nxt;
  always_comb begin
    own_vec = '0;
    own_vec[OWN_SLOT] = irq_nxt;
  end
  assign summary_nxt = 8'((irq_s2_r | wake_s2_r | own_vec)
                          & {NUM_SLOTS{!full_rst_r}});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_r <= 8'h00;
    end else if (pce) begin
      summary_r <= summary_nxt;
    end
  end

  // Read mux; reserved bits and the force location read zero
  logic [15:0] rd_val;
  always_comb begin
    case (reg_sel)
      SIRQ_REG_SUMMARY: rd_val = {8'h00, summary_r};
      SIRQ_REG_VERSION: rd_val = {VENDOR_VER, SPEC_VER};
      SIRQ_REG_ERR_STS: rd_val = err_sts_r;
      SIRQ_REG_STS_EN: rd_val = sts_en_r;
      SIRQ_REG_SIG_EN: rd_val = sig_en_r;
      SIRQ_REG_FORCE: rd_val = 16'h0000;
      SIRQ_REG_CTRL: rd_val = 16'h0000;
      default: rd_val = 16'h0000;
    endcase
  end

  logic [31:0] prdata_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (pce && req.sel && !req.en && !req.wr) begin
      prdata_r <= {16'h0000, rd_val};
    end
  end

  // Zero wait states while enabled; a stopped clock enable stalls
  assign pready = pce;
  assign pslverr = access && (unmapped || (req.wr && ro_hit));
  assign prdata = prdata_r;
  assign irq = irq_r;
  assign full_controller_reset = full_rst_r;

  // Checks: slot summary
  chk_summary_or: assert property (
    pce && !full_rst_r |=> summary_r[NUM_SLOTS-1:0] ==
      ($past(irq_s2_r) | $past(wake_s2_r) | $past(own_vec)))
    else $error("summary bit not OR of slot requests");

  chk_summary_rsvd: assert property (
    access && reg_sel == SIRQ_REG_SUMMARY && !req.wr
    |-> prdata[31:8] == 24'h000000)
    else $error("summary reserved bits not zero");

  chk_slot_map: assert property (
    pce && !full_rst_r && irq_s2_r[NUM_SLOTS-1]
    |=> summary_r[NUM_SLOTS-1])
    else $error("last slot not on its summary bit");

  chk_wake_map: assert property (
    pce && !full_rst_r && wake_s2_r[0] |=> summary_r[0])
    else $error("first slot wake not on its summary bit");

  // Checks: full controller reset
  chk_full_reset_irq: assert property (
    pce && full_rst_r |=> !irq && err_sts_r == 16'h0000)
    else $error("full reset left interrupt set");

  chk_reset_summary: assert property (
    pce && full_rst_r |=> summary_r == 8'h00)
    else $error("full reset left a summary bit");

  chk_reset_pulse: assert property (
    pce && full_rst_r |=> !full_rst_r)
    else $error("full reset pulse wider than one cycle");

  // Checks: revision register
  chk_version_upper: assert property (
    access && reg_sel == SIRQ_REG_VERSION && !req.wr
    |-> prdata[15:8] == VENDOR_VER)
    else $error("maker revision byte wrong");

  chk_version_read: assert property (
    access && reg_sel == SIRQ_REG_VERSION && !req.wr
    |-> prdata == {16'h0000, VENDOR_VER, SPEC_VER})
    else $error("version read wrong");

  // Checks: force path and error status
  chk_no_store: assert property (
    wr_force |=> $stable(sts_en_r) && $stable(sig_en_r))
    else $error("force write altered an enable");

  chk_force_sets: assert property (
    wr_force && !full_rst_r |=>
    ((err_sts_r | ~($past(wval) & $past(sts_en_r)))
     | ~`SIRQ_ERR_VALID) == 16'hFFFF)
    else $error("forced bit not set");

  chk_force_keeps: assert property (
    wr_force && !full_rst_r |=>
    (err_sts_r & $past(err_sts_r)) == $past(err_sts_r))
    else $error("force write cleared a bit");

  chk_force_gated: assert property (
    pce && !full_rst_r && wr_force && sts_en_r == 16'h0000
    && evt_s2_r == 16'h0000 |=> err_sts_r == $past(err_sts_r))
    else $error("disabled forced bit appeared");

  chk_evt_sets: assert property (
    pce && !full_rst_r |=>
    ((err_sts_r | ~($past(evt_s2_r) & $past(sts_en_r)))
     | ~`SIRQ_ERR_VALID) == 16'hFFFF)
    else $error("enabled event bit not set");

  // A held event must survive a clear in the same cycle
  chk_set_wins: assert property (
    pce && !full_rst_r && (set_bits & clr_bits) != 16'h0000
    |=> (err_sts_r & $past(set_bits)) == $past(set_bits))
    else $error("clear beat a same-cycle set");

  chk_w1c_clear: assert property (
    wr_sts && !full_rst_r |=>
    (err_sts_r & $past(clr_bits) & ~$past(set_bits)) == 16'h0000)
    else $error("written one did not clear status");

  chk_sts_en_keep: assert property (
    wr_sts_en && !full_rst_r |=>
    (err_sts_r & $past(err_sts_r)) == $past(err_sts_r))
    else $error("enable write dropped a status bit");

  // Checks: interrupt output and reserved error bits
  chk_irq_gate: assert property (
    pce ##1 ((err_sts_r & sig_en_r) == 16'h0000) |-> !irq)
    else $error("interrupt without enabled status");

  chk_irq_on: assert property (
    pce ##1 ((err_sts_r & sig_en_r) != 16'h0000) |-> irq)
    else $error("enabled status without interrupt");

  chk_layout_rsvd: assert property (
    err_sts_r[11:10] == 2'b00 && sts_en_r[11:10] == 2'b00
    && sig_en_r[11:10] == 2'b00)
    else $error("reserved error bits set");

  // Checks: reads and bus answers
  chk_force_reads_zero: assert property (
    access && reg_sel == SIRQ_REG_FORCE && !req.wr
    |-> prdata == 32'h0000_0000)
    else $error("force location read not zero");

  chk_ctrl_reads_zero: assert property (
    access && reg_sel == SIRQ_REG_CTRL && !req.wr
    |-> prdata == 32'h0000_0000)
    else $error("control location read not zero");

  chk_read_upper: assert property (
    access && !req.wr |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  chk_pready_ce: assert property (
    pready == pce)
    else $error("ready does not follow clock enable");

  chk_ro_write_err: assert property (
    access && req.wr && ro_hit |-> pslverr)
    else $error("write to read-only location not refused");

endmodule

// ### verif/sirq_tb.sv
// Purpose: Self-checking bench for the slot irq, revision and force block
// Assumes: pce high except in the freeze scenario; no wait states then
// Notes: Expected values come from the cfg constants and the rules
`timescale 1ns/1ps
`include "sirq_cfg.svh"
module testbench;
  import sirq_pkg::*;
  localparam logic [11:0] A_FRC = `SIRQ_BYTE_ADDR(`SIRQ_IDX_FORCE);
  localparam logic [11:0] A_SUM = `SIRQ_BYTE_ADDR(`SIRQ_IDX_SUMMARY);
  localparam logic [11:0] A_VER = `SIRQ_BYTE_ADDR(`SIRQ_IDX_VERSION);
  localparam logic [11:0] A_CTL = `SIRQ_BYTE_ADDR(`SIRQ_IDX_CTRL);
  localparam logic [11:0] A_STS = `SIRQ_BYTE_ADDR(`SIRQ_IDX_ERR_STS);
  localparam logic [11:0] A_SEN = `SIRQ_BYTE_ADDR(`SIRQ_IDX_STS_EN);
  localparam logic [11:0] A_GEN = `SIRQ_BYTE_ADDR(`SIRQ_IDX_SIG_EN);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] slot_irq = 8'h00;
  logic [7:0] slot_wake = 8'h00;
  logic pce = 1'b1;
  logic [15:0] err_event = 16'h0000;
  int rst_pulses = 0;
  logic irq;
  logic full_controller_reset;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int total_checks = 0;

  always #5 pclk = ~pclk;

  // Tied: byte lanes stay all on
  sirq_top dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_irq(slot_irq), .slot_wake(slot_wake), .err_event(err_event),
    .irq(irq), .full_controller_reset(full_controller_reset));

  // Counts cycles with the reset pulse high
  always @(posedge pclk) begin
    if (full_controller_reset === 1'b1) begin
      rst_pulses <= rst_pulses + 1;
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; idle edge after release
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      error_cnt++;
      complete_run();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic reset_values();
    chk({31'b0, irq}, 32'h0000_0000);
    apb(1'b0, A_VER, 32'h0);
    chk(rdat, {16'h0000, `SIRQ_VENDOR_VER, `SIRQ_SPEC_V200});
    apb(1'b0, A_FRC, 32'h0);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, A_VER, 32'h0000_FFFF);
    chk({31'b0, rerr}, 32'h0000_0001);
    apb(1'b0, A_VER, 32'h0);
    chk(rdat, {16'h0000, `SIRQ_VENDOR_VER, `SIRQ_SPEC_V200});
    apb(1'b0, 12'h400, 32'h0);
    chk({31'b0, rerr}, 32'h0000_0001);
  endtask

  // Each slot alone, request and wake taking turns
  task automatic slot_walk();
    for (int i = 0; i < 8; i++) begin
      slot_irq <= (i % 2 == 0) ? 8'(1 << i) : 8'h00;
      slot_wake <= (i % 2 == 1) ? 8'(1 << i) : 8'h00;
      repeat (4) @(posedge pclk);
      apb(1'b0, A_SUM, 32'h0);
      chk(rdat, 32'(1 << i));
    end
    slot_irq <= 8'hA5;
    slot_wake <= 8'h5A;
    repeat (4) @(posedge pclk);
    apb(1'b0, A_SUM, 32'h0);
    chk(rdat, 32'h0000_00FF);
    slot_irq <= 8'h00;
    slot_wake <= 8'h00;
    repeat (4) @(posedge pclk);
  endtask

  // Stopped clock enable: no ready, synchronisers frozen
  task automatic freeze_check();
    pce <= 1'b0;
    slot_irq <= 8'h02;
    @(posedge pclk);
    chk({31'b0, pready}, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    pce <= 1'b1;
    apb(1'b0, A_SUM, 32'h0);
    chk(rdat, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    apb(1'b0, A_SUM, 32'h0);
    chk(rdat, 32'h0000_0002);
    slot_irq <= 8'h00;
    repeat (4) @(posedge pclk);
  endtask

  // Held core event sets status and outlasts a clear
  task automatic event_path();
    apb(1'b1, A_SEN, 32'h0000_FFFF);
    err_event <= 16'h0010;
    repeat (4) @(posedge pclk);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0010);
    chk({31'b0, irq}, 32'h0000_0000);
    apb(1'b1, A_STS, 32'h0000_0010);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0010);
    err_event <= 16'h0000;
    repeat (4) @(posedge pclk);
    apb(1'b1, A_STS, 32'h0000_0010);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0000);
  endtask

  task automatic force_path();
    apb(1'b1, A_FRC, 32'h0000_FFFF);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, A_SEN, 32'h0000_FFFF);
    apb(1'b1, A_FRC, 32'h0000_0005);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0005);
    chk({31'b0, irq}, 32'h0000_0000);
    apb(1'b1, A_FRC, 32'h0000_0000);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0005);
    apb(1'b1, A_GEN, 32'h0000_0004);
    chk({31'b0, irq}, 32'h0000_0001);
    apb(1'b0, A_SUM, 32'h0);
    chk(rdat, 32'h0000_0001);
    apb(1'b1, A_FRC, 32'h0000_FFFF);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, {16'h0000, `SIRQ_ERR_VALID});
    apb(1'b0, A_FRC, 32'h0);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, A_STS, 32'h0000_0004);
    chk({31'b0, irq}, 32'h0000_0000);
  endtask

  // Full reset must drop irq and wipe status
  task automatic full_reset();
    apb(1'b1, A_GEN, 32'h0000_FFFF);
    chk({31'b0, irq}, 32'h0000_0001);
    apb(1'b1, A_CTL, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'b0, irq}, 32'h0000_0000);
    chk(32'(rst_pulses), 32'h0000_0001);
    apb(1'b0, A_STS, 32'h0);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, A_SUM, 32'h0);
    chk(rdat, 32'h0000_0000);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values();
    slot_walk();
    freeze_check();
    force_path();
    full_reset();
    event_path();
    complete_run();
  end
endmodule
